// File: rbsc_pkg.sv
// Package for the ROM bank capacity register: offsets, field layout,
// reset value, capacity codes and the shared bus request carrier.
// Assumes a single 125 MHz core clock domain and a plain register port.
package rbsc_pkg;

  // ***********************************************************************
  // Register map and layout
  // ***********************************************************************
  localparam int RBSC_REG_W = 16;
  localparam int RBSC_ADDR_W = 32;
  localparam int RBSC_FIELD_W = 3;
  localparam int RBSC_NBANK = 4;
  localparam int RBSC_MB_W = 7;
  localparam logic [31:0] RBSC_CAP_OFFSET = 32'h0f00_0004;
  localparam int RBSC_HI_A_LSB = 12;
  localparam int RBSC_HI_B_LSB = 8;
  localparam int RBSC_LO_A_LSB = 4;
  localparam int RBSC_LO_B_LSB = 0;
  localparam int RBSC_FIELD_PITCH = 4;
  localparam logic [15:0] RBSC_RSVD_MASK = 16'h8888;
  localparam logic [15:0] RBSC_CAP_RESET = 16'h1111;
  // Cycles from a write strobe to the bank outputs showing the new code.
  localparam int RBSC_WR_TO_OUT = 2;

  // ***********************************************************************
  // Capacity codes
  // ***********************************************************************
  localparam logic [2:0] RBSC_CODE_4MB = 3'h1;
  localparam logic [2:0] RBSC_CODE_8MB = 3'h2;
  localparam logic [2:0] RBSC_CODE_16MB = 3'h3;
  localparam logic [2:0] RBSC_CODE_32MB = 3'h4;
  localparam logic [2:0] RBSC_CODE_64MB = 3'h5;
  localparam logic [6:0] RBSC_MB_NONE = 7'h00;

  // ***********************************************************************
  // Types
  // ***********************************************************************
  typedef logic [RBSC_FIELD_W-1:0] rbsc_code_t;
  typedef logic [RBSC_NBANK-1:0][RBSC_FIELD_W-1:0] rbsc_codes_t;
  typedef logic [RBSC_NBANK-1:0][RBSC_MB_W-1:0] rbsc_mbs_t;

  typedef struct packed {
    logic [RBSC_ADDR_W-1:0] addr;
    logic [RBSC_REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } rbsc_bus_req_t;

  // Capacity in megabytes for a code; reserved codes give zero.
  function automatic logic [6:0] rbsc_code_to_mb(input logic [2:0] code);
    logic [6:0] mb;
    mb = RBSC_MB_NONE;
    unique case (code)
      RBSC_CODE_4MB: mb = 7'h04;
      RBSC_CODE_8MB: mb = 7'h08;
      RBSC_CODE_16MB: mb = 7'h10;
      RBSC_CODE_32MB: mb = 7'h20;
      RBSC_CODE_64MB: mb = 7'h40;
      default: mb = RBSC_MB_NONE;
    endcase
    return mb;
  endfunction

  // Field index that drives a physical bank in the selected bus width.
  function automatic int rbsc_field_of_bank(input int bank, input logic mode_32);
    return mode_32 ? (bank ^ 2) : bank;
  endfunction

endpackage

// File: rbsc_bank_map.sv
// Combinational steering of the four capacity fields onto physical banks.
// Assumes its caller registers the results before they leave the block.
`timescale 1ns/1ns
module rbsc_bank_map (
  // Register contents and bus width
  input wire logic [15:0] cap_word_i,
  input wire logic mode_32_i,
  // Per-bank results
  output rbsc_pkg::rbsc_codes_t bank_code_o,
  output rbsc_pkg::rbsc_mbs_t bank_mb_o
);
  import rbsc_pkg::*;

  always_comb begin
    for (int b = 0; b < RBSC_NBANK; b++) begin
      bank_code_o[b] = cap_word_i[rbsc_field_of_bank(b, mode_32_i) * RBSC_FIELD_PITCH +:
                                  RBSC_FIELD_W];
      bank_mb_o[b] = rbsc_code_to_mb(bank_code_o[b]);
    end
  end

endmodule // rbsc_bank_map

// File: rbsc_cap_reg.sv
// ROM bank capacity register with its plain register port and the
// registered per-bank capacity outputs for the chip-select decoder.
// Assumes one core clock, synchronous inputs and a master that never
// raises read and write strobes together.
//
// Functional notes
// - Bits 15, 11, 7 and 3 are reserved, always read zero, and software writes zero there.
// - Bits 14 to 12 size bank 3 on a 16-bit ROM bus and bank 1 on a 32-bit bus.
// - Bits 6 to 4 size bank 1 on a 16-bit ROM bus and bank 3 on a 32-bit bus.
// - Bits 2 to 0 size bank 0 on a 16-bit ROM bus and bank 2 on a 32-bit bus.
// - Codes 1 to 5 mean 4, 8, 16, 32 and 64 MB in either width; 0, 6 and 7 are reserved.
`timescale 1ns/1ns
module rbsc_cap_reg (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input rbsc_pkg::rbsc_bus_req_t bus_req_i,
  output logic [15:0] rd_data_o,
  // ROM bus width, high for 32-bit mode
  input wire logic rom_bus_32_i,
  // Chip-select decoder side
  output rbsc_pkg::rbsc_codes_t bank_code_o,
  output rbsc_pkg::rbsc_mbs_t bank_mb_o,
  output logic code_reserved_o
);
  import rbsc_pkg::*;

  // ***********************************************************************
  // Decode
  // ***********************************************************************
  logic [15:0] cap_r;
  logic [15:0] cap_nxt;
  logic hit;
  logic wr_hit;
  logic rd_hit;
  rbsc_codes_t map_code;
  rbsc_mbs_t map_mb;
  logic any_rsvd;

  assign hit = (bus_req_i.addr == RBSC_CAP_OFFSET);
  assign wr_hit = bus_req_i.wr && hit;
  assign rd_hit = bus_req_i.rd && hit;

  // ***********************************************************************
  // Register storage
  // ***********************************************************************
  // Reserved bits are dropped on write so a careless write cannot make them read back.
  assign cap_nxt = bus_req_i.wdata & ~RBSC_RSVD_MASK;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cap_r <= RBSC_CAP_RESET;
    end else if (wr_hit) begin
      cap_r <= cap_nxt;
    end
  end

  // ***********************************************************************
  // Read path
  // ***********************************************************************
  // Unmapped reads answer zero; data stands for the one cycle after the strobe.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 16'h0000;
    end else if (rd_hit) begin
      rd_data_o <= cap_r & ~RBSC_RSVD_MASK;
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  // ***********************************************************************
  // Bank steering
  // ***********************************************************************
  rbsc_bank_map u_map (
    .cap_word_i(cap_r),
    .mode_32_i(rom_bus_32_i),
    .bank_code_o(map_code),
    .bank_mb_o(map_mb)
  );

  always_comb begin
    any_rsvd = 1'b0;
    for (int b = 0; b < RBSC_NBANK; b++) begin
      if (map_mb[b] == RBSC_MB_NONE) begin
        any_rsvd = 1'b1;
      end
    end
  end

  // Outputs are registered so the decoder sees clean levels; this costs one
  // cycle of latency after a write or a bus width change.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int b = 0; b < RBSC_NBANK; b++) begin
        bank_code_o[b] <= RBSC_CODE_4MB;
        bank_mb_o[b] <= 7'h04;
      end
    end else begin
      bank_code_o <= map_code;
      bank_mb_o <= map_mb;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      code_reserved_o <= 1'b0;
    end else begin
      code_reserved_o <= any_rsvd;
    end
  end

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic past_valid_r;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      past_valid_r <= 1'b0;
    end else begin
      past_valid_r <= 1'b1;
    end
  end

  rsvd_read_zero_a: assert property (
    (rd_data_o & RBSC_RSVD_MASK) == 16'h0000
  ) else $error("reserved bits read as nonzero");

  rsvd_store_zero_a: assert property (
    wr_hit |=> ((cap_r & RBSC_RSVD_MASK) == 16'h0000)
  ) else $error("reserved bits stored after write");

  read_answer_a: assert property (
    rd_hit && !wr_hit |=> rd_data_o == $past(cap_r & ~RBSC_RSVD_MASK)
  ) else $error("read data does not match register");

  unmapped_read_a: assert property (
    !rd_hit |=> rd_data_o == 16'h0000
  ) else $error("read data not zero outside a mapped read");

  write_to_out_a: assert property (
    wr_hit && !rom_bus_32_i ##1 !wr_hit && !rom_bus_32_i
      |=> bank_code_o[3] == $past(bus_req_i.wdata[14:12], 2)
  ) else $error("bank 3 code not updated two cycles after write");

  hi_a_map_a: assert property (
    past_valid_r |-> bank_code_o[$past(rom_bus_32_i) ? 1 : 3] == $past(cap_r[14:12])
  ) else $error("upper field steered to wrong bank");

  hi_b_map_a: assert property (
    past_valid_r |-> bank_code_o[$past(rom_bus_32_i) ? 0 : 2] == $past(cap_r[10:8])
  ) else $error("second field steered to wrong bank");

  lo_a_map_a: assert property (
    past_valid_r |-> bank_code_o[$past(rom_bus_32_i) ? 3 : 1] == $past(cap_r[6:4])
  ) else $error("third field steered to wrong bank");

  lo_b_map_a: assert property (
    past_valid_r |-> bank_code_o[$past(rom_bus_32_i) ? 2 : 0] == $past(cap_r[2:0])
  ) else $error("lowest field steered to wrong bank");

  mb_decode_a: assert property (
    bank_mb_o[0] == rbsc_code_to_mb(bank_code_o[0]) &&
    bank_mb_o[1] == rbsc_code_to_mb(bank_code_o[1]) &&
    bank_mb_o[2] == rbsc_code_to_mb(bank_code_o[2]) &&
    bank_mb_o[3] == rbsc_code_to_mb(bank_code_o[3])
  ) else $error("capacity in megabytes disagrees with code");

  rsvd_flag_a: assert property (
    code_reserved_o == ((bank_mb_o[0] == RBSC_MB_NONE) || (bank_mb_o[1] == RBSC_MB_NONE) ||
                        (bank_mb_o[2] == RBSC_MB_NONE) || (bank_mb_o[3] == RBSC_MB_NONE))
  ) else $error("reserved code flag wrong");

  reset_value_a: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
    $fell(sys_rst_i) |-> cap_r == RBSC_CAP_RESET && bank_code_o[0] == RBSC_CODE_4MB &&
      bank_code_o[3] == RBSC_CODE_4MB && !code_reserved_o
  ) else $error("register not at 4 MB codes after reset");

  hold_value_a: assert property (
    !wr_hit |=> $stable(cap_r)
  ) else $error("register changed without a write");

  // ***********************************************************************
  // Register port checks
  // ***********************************************************************
  // A write lands at its own edge, so a read in the very next cycle sees it.
  write_lands_a: assert property (
    wr_hit |=> cap_r == $past(bus_req_i.wdata & ~RBSC_RSVD_MASK)
  ) else $error("write data not stored");

  unmapped_write_a: assert property (
    bus_req_i.wr && !hit |=> $stable(cap_r)
  ) else $error("unmapped write changed the register");

  back_to_back_a: assert property (
    wr_hit ##1 rd_hit
      |=> rd_data_o == $past(bus_req_i.wdata & ~RBSC_RSVD_MASK, 2)
  ) else $error("read right after write returned stale data");

  idle_read_zero_a: assert property (
    !past_valid_r |-> rd_data_o == 16'h0000
  ) else $error("read data not zero after reset");

  cap_rsvd_zero_a: assert property (
    (cap_r & RBSC_RSVD_MASK) == 16'h0000
  ) else $error("reserved bits held in register");

  // ***********************************************************************
  // Output stability checks
  // ***********************************************************************
  // The decoder must see steady levels while neither the register nor the
  // bus width moves; a glitch here would resize a bank mid-access.
  code_steady_a: assert property (
    !wr_hit ##1 $stable(rom_bus_32_i) |=> $stable(bank_code_o)
  ) else $error("bank codes moved without a cause");

  mb_steady_a: assert property (
    !wr_hit ##1 $stable(rom_bus_32_i) |=> $stable(bank_mb_o)
  ) else $error("bank sizes moved without a cause");

  flag_steady_a: assert property (
    !wr_hit ##1 $stable(rom_bus_32_i) |=> $stable(code_reserved_o)
  ) else $error("reserved flag moved without a cause");

  // ***********************************************************************
  // Capacity code checks
  // ***********************************************************************
  legal_mb0_a: assert property (
    bank_mb_o[0] != RBSC_MB_NONE
      |-> bank_code_o[0] inside {[RBSC_CODE_4MB:RBSC_CODE_64MB]}
  ) else $error("bank 0 size given for a reserved code");

  legal_mb1_a: assert property (
    bank_mb_o[1] != RBSC_MB_NONE
      |-> bank_code_o[1] inside {[RBSC_CODE_4MB:RBSC_CODE_64MB]}
  ) else $error("bank 1 size given for a reserved code");

  legal_mb2_a: assert property (
    bank_mb_o[2] != RBSC_MB_NONE
      |-> bank_code_o[2] inside {[RBSC_CODE_4MB:RBSC_CODE_64MB]}
  ) else $error("bank 2 size given for a reserved code");

  legal_mb3_a: assert property (
    bank_mb_o[3] != RBSC_MB_NONE
      |-> bank_code_o[3] inside {[RBSC_CODE_4MB:RBSC_CODE_64MB]}
  ) else $error("bank 3 size given for a reserved code");

  rsvd_mb0_a: assert property (
    bank_code_o[0] inside {3'h0, 3'h6, 3'h7} |-> bank_mb_o[0] == RBSC_MB_NONE
  ) else $error("bank 0 reserved code shows a size");

  rsvd_mb1_a: assert property (
    bank_code_o[1] inside {3'h0, 3'h6, 3'h7} |-> bank_mb_o[1] == RBSC_MB_NONE
  ) else $error("bank 1 reserved code shows a size");

  rsvd_mb2_a: assert property (
    bank_code_o[2] inside {3'h0, 3'h6, 3'h7} |-> bank_mb_o[2] == RBSC_MB_NONE
  ) else $error("bank 2 reserved code shows a size");

  rsvd_mb3_a: assert property (
    bank_code_o[3] inside {3'h0, 3'h6, 3'h7} |-> bank_mb_o[3] == RBSC_MB_NONE
  ) else $error("bank 3 reserved code shows a size");

  // Sizes are powers of two from 4 to 64 MB, or zero for a reserved code.
  mb_values_a: assert property (
    bank_mb_o[0] inside {7'h00, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40} &&
    bank_mb_o[1] inside {7'h00, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40} &&
    bank_mb_o[2] inside {7'h00, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40} &&
    bank_mb_o[3] inside {7'h00, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40}
  ) else $error("bank size outside the legal set");

  write_then_read_c: cover property (
    wr_hit ##1 rd_hit ##1 rd_data_o != RBSC_CAP_RESET
  );
  mode_switch_c: cover property (
    $rose(rom_bus_32_i) ##1 bank_code_o[0] != bank_code_o[2]
  );
  max_size_c: cover property (
    bank_mb_o[3] == 7'h40
  );
  reserved_code_c: cover property (
    code_reserved_o
  );

endmodule // rbsc_cap_reg

// File: rom_bank_size_config_test.sv
// Self-checking testbench for the ROM bank capacity register.
// Assumes rbsc_pkg and rbsc_cap_reg are compiled first; no partner model.
`timescale 1ns/1ns
module rom_bank_size_config_test;
  import rbsc_pkg::*;

  // ***********************************************************************
  // Stimulus and observation
  // ***********************************************************************
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  rbsc_bus_req_t req = '0;
  logic rom_bus_32 = 1'b0;
  logic [15:0] rd_data;
  rbsc_codes_t bank_code;
  rbsc_mbs_t bank_mb;
  logic code_reserved;
  int n_errors = 0;
  int tests_run = 0;
  localparam logic [31:0] MAPPED = 32'h0f00_0004;

  always #4 core_clk_i = ~core_clk_i;

  rbsc_cap_reg DUT (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .bus_req_i(req),
    .rd_data_o(rd_data),
    .rom_bus_32_i(rom_bus_32),
    .bank_code_o(bank_code),
    .bank_mb_o(bank_mb),
    .code_reserved_o(code_reserved)
  );

  // ***********************************************************************
  // Shared tasks
  // ***********************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One strobe cycle; returns just after the edge that takes it.
  task automatic bus(input logic [31:0] a, input logic [15:0] d, input logic w);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    #1;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp);
    bus(a, 16'h0000, 1'b0);
    chk(rd_data, exp);
  endtask

  // Write, then let the two-edge path to the bank outputs settle.
  task automatic wr_settle(input logic [15:0] d);
    bus(MAPPED, d, 1'b1);
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask

  // The 32-bit bus swaps bank pairs, so field index is bank xor 2 there.
  task automatic chk_banks(input logic [15:0] w, input logic m32);
    logic [2:0] code;
    logic any_rsvd;
    int f;
    any_rsvd = 1'b0;
    for (int b = 0; b < 4; b++) begin
      f = m32 ? (b ^ 2) : b;
      code = w[f*4 +: 3];
      chk(16'(bank_code[b]), 16'(code));
      if (code >= 3'h1 && code <= 3'h5) begin
        chk(16'(bank_mb[b]), 16'h0004 << (code - 3'h1));
      end else begin
        any_rsvd = 1'b1;
        chk(16'(bank_mb[b]), 16'h0000);
      end
    end
    chk(16'(code_reserved), 16'(any_rsvd));
  endtask

  task automatic set_mode(input logic m32);
    @(posedge core_clk_i);
    rom_bus_32 <= m32;
    @(posedge core_clk_i);
    #1;
  endtask

  // ***********************************************************************
  // Scenarios
  // ***********************************************************************
  task automatic test_reset_values();
    rd_chk(MAPPED, 16'h1111);
    chk_banks(16'h1111, rom_bus_32);
    $display("test_reset_values done");
  endtask

  // Every legal code in every field, with reserved bits written as one.
  task automatic test_all_codes();
    logic [15:0] w;
    for (int c = 1; c <= 5; c++) begin
      w = {4{1'b1, 3'(c)}};
      wr_settle(w);
      rd_chk(MAPPED, w & 16'h7777);
      @(posedge core_clk_i);
      #1;
      chk(rd_data, 16'h0000);
      chk_banks(w, 1'b0);
    end
    $display("test_all_codes done");
  endtask

  // Distinct codes per field expose any crossed steering in either width.
  task automatic test_mapping();
    wr_settle(16'h5432);
    chk_banks(16'h5432, 1'b0);
    set_mode(1'b1);
    chk_banks(16'h5432, 1'b1);
    wr_settle(16'h2345);
    chk_banks(16'h2345, 1'b1);
    set_mode(1'b0);
    chk_banks(16'h2345, 1'b0);
    $display("test_mapping done");
  endtask

  task automatic test_reserved_and_unmapped();
    wr_settle(16'hf0e6);
    rd_chk(MAPPED, 16'h7066);
    chk_banks(16'h7066, 1'b0);
    bus(32'h0f00_0006, 16'h5555, 1'b1);
    rd_chk(MAPPED, 16'h7066);
    rd_chk(32'h0f00_0006, 16'h0000);
    // Back-to-back write then read, with no idle cycle between the strobes.
    @(posedge core_clk_i);
    req <= '{addr: MAPPED, wdata: 16'h9235, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req <= '{addr: MAPPED, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req <= '{addr: MAPPED, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
    #1;
    chk(rd_data, 16'h1235);
    $display("test_reserved_and_unmapped done");
  endtask

  // A second reset in mid-run, while the 32-bit width is selected.
  task automatic test_second_reset();
    wr_settle(16'h4444);
    set_mode(1'b1);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk_banks(16'h1111, 1'b1);
    sys_rst_i <= 1'b0;
    rd_chk(MAPPED, 16'h1111);
    set_mode(1'b0);
    $display("test_second_reset done");
  endtask

  // ***********************************************************************
  // Main sequence and verdict
  // ***********************************************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    test_reset_values();
    test_all_codes();
    test_mapping();
    test_reserved_and_unmapped();
    test_second_reset();
    print_verdict();
  end
endmodule // rom_bank_size_config_test
